// ### rtl/tmr_timer2.sv
/*
 * 16-bit timer/counter with capture, auto-reload with optional
 * down counting, baud tick generation and clock output, plus
 * the hardware-clear enables of external interrupts 2 to 5.
 * Assumes pins synchronous to clk, a register port with read
 * data one cycle after the read strobe, and interrupt entry
 * pulses from the core.
 */
// How it works
// [R1] Overflow flag set on 16-bit rollover
// [R2] Down count: flag also set at reload match
// [R3] Overflow flag set only with baud selects low
// [R4] Overflow flag cleared only by software
// [R5] Edge flag set by trigger edge, or by overflow in down count
// [R6] Edge flag raises timer request; software clears
// [R7] Receive baud select picks source, forces baud mode
// [R8] Transmit baud select picks source, forces baud mode
// [R9] Trigger edge captures or reloads when enabled
// [R10] Run bit stops counting, holds count
// [R11] Baud mode advances every 2 clocks
// [R12] Timer counts clocks or count pin falling edges
// [R13] Baud select forces auto-reload on overflow
// [R14] Reload mode reloads on overflow or trigger edge
// [R15] Capture mode copies count on trigger edge
// [R16] Capture reset clears count after capture
// [R17] Output enable switches clock-out function
// [R18] Down enable and trigger level set direction
// [R19] Reload pair doubles as capture pair
// [R20] Hardware-clear bits clear irq flags on entry
// [R21] Trigger high counts up, low counts down
// [R22] Falling edges found by sampling synced pins
`default_nettype none

module tmr_timer2
	import tmr_pkg::*;
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Register port
	input  wire tmr_bus_req_t bus_req,
	output var  logic [7:0]   rdata,
	// Trigger and count pins
	input  wire logic         trigger_pin,
	input  wire logic         count_pin_i,
	output var  logic         count_pin_o,
	output var  logic         count_pin_oe,
	// Serial port baud source
	output var  logic         baud_tick,
	// Timer interrupt requests
	output var  logic         tmr_overflow_flag,
	output var  logic         ext_edge_flag,
	// External interrupts 2 to 5
	input  wire logic [3:0]   irq_flag_set,
	input  wire logic [3:0]   irq_enter,
	output var  logic [3:0]   irq_flag
);

	// High-to-low change between two samples
	function automatic logic fall(input logic prev, input logic cur);
		fall = prev & ~cur;
	endfunction : fall

	// Register state
	tmr_ctrl_t      ctrl_r;
	tmr_ctrl_t      ctrl_nxt;
	tmr_mode_ctrl_t mode_r;
	tmr_mode_ctrl_t mode_nxt;
	logic [15:0]    cnt_r;
	logic [15:0]    cnt_nxt;
	logic [15:0]    rcap_r;
	logic [15:0]    rcap_nxt;
	logic           fast_r;
	logic           fast_nxt;
	logic [3:0]     xirq_r;
	logic [3:0]     xirq_nxt;

	// Counting state
	logic [3:0]     presc_r;
	logic [3:0]     presc_nxt;
	logic [2:0]     trig_s_r;
	logic [2:0]     trig_s_nxt;
	logic [2:0]     cpin_s_r;
	logic [2:0]     cpin_s_nxt;

	// Output state
	logic [7:0]     rdata_r;
	logic [7:0]     rdata_nxt;
	logic           cko_r;
	logic           cko_nxt;
	logic           baud_r;
	logic           baud_nxt;

	// Working terms
	tmr_mode_t      mode;
	logic           baud_mode;
	logic [3:0]     div;
	logic           ptick;
	logic           inc;
	logic           up;
	logic           trig_edge;
	logic           cpin_edge;
	logic           ovf;
	logic           tf_set;
	logic           ef_set;

	// Mode selection and tick generation
	// Baud selects outrank capture, capture outranks down count
	always_comb begin
		baud_mode = ctrl_r.rx_baud_select | ctrl_r.tx_baud_select; // [R7] [R8]
		if (baud_mode) begin
			mode = TMR_M_BAUD; // [R13]
		end else if (ctrl_r.capture_reload_select) begin
			mode = TMR_M_CAPTURE;
		end else if (mode_r.down_count_enable) begin
			mode = TMR_M_DOWN;
		end else begin
			mode = TMR_M_RELOAD;
		end
		// Clocks per tick
		if (baud_mode) begin
			div = TMR_BAUD_DIV; // [R11]
		end else if (fast_r) begin
			div = TMR_FAST_DIV; // [R12]
		end else begin
			div = TMR_SLOW_DIV; // [R12]
		end
		// Synced pin edges and level
		// Third stage keeps the previous sample for the edge
		trig_edge = fall(trig_s_r[2], trig_s_r[1]); // [R22]
		cpin_edge = fall(cpin_s_r[2], cpin_s_r[1]); // [R22]
		up = trig_s_r[1]; // [R21]
		// Prescaler
		// Held at zero while stopped, so a restart waits a full tick
		ptick = 1'b0;
		presc_nxt = 4'h0;
		if (ctrl_r.run_control) begin
			if (presc_r == 4'(div - 4'h1)) begin
				ptick = 1'b1;
			end else begin
				presc_nxt = presc_r + 4'h1;
			end
		end
		// Advance only while running
		// Count pin edges are ignored in baud mode
		if (!ctrl_r.run_control) begin
			inc = 1'b0; // [R10]
		end else if (baud_mode || !ctrl_r.count_source_select) begin
			inc = ptick; // [R11] [R12]
		end else begin
			inc = cpin_edge; // [R12]
		end
	end

	// Next state of all registers except the prescaler
	always_comb begin
		ctrl_nxt = ctrl_r;
		mode_nxt = mode_r;
		cnt_nxt = cnt_r;
		rcap_nxt = rcap_r;
		fast_nxt = fast_r;
		xirq_nxt = xirq_r;
		cko_nxt = cko_r;
		baud_nxt = 1'b0;
		rdata_nxt = 8'h00;
		ovf = 1'b0;
		tf_set = 1'b0;
		ef_set = 1'b0;
		trig_s_nxt = {trig_s_r[1:0], trigger_pin};
		cpin_s_nxt = {cpin_s_r[1:0], count_pin_i};

		// Hardware counting per mode
		// A trigger edge is applied last so it beats the count step
		unique case (mode)
			TMR_M_CAPTURE: begin
				if (inc) begin
					cnt_nxt = cnt_r + 16'h0001;
					if (cnt_r == TMR_CNT_MAX) begin
						ovf = 1'b1;
						tf_set = 1'b1; // [R1]
					end
				end
				if (trig_edge && ctrl_r.ext_trigger_enable) begin
					rcap_nxt = cnt_r; // [R9] [R15] [R19]
					ef_set = 1'b1; // [R5]
					if (mode_r.capture_reset_enable) begin
						cnt_nxt = TMR_CNT_ZERO; // [R16]
					end
				end
			end
			TMR_M_RELOAD: begin
				if (inc) begin
					if (cnt_r == TMR_CNT_MAX) begin
						cnt_nxt = rcap_r; // [R14] [R19]
						ovf = 1'b1;
						tf_set = 1'b1; // [R1]
					end else begin
						cnt_nxt = cnt_r + 16'h0001;
					end
				end
				if (trig_edge && ctrl_r.ext_trigger_enable) begin
					cnt_nxt = rcap_r; // [R9] [R14]
					ef_set = 1'b1; // [R5]
				end
			end
			TMR_M_DOWN: begin
				if (inc && up) begin
					if (cnt_r == TMR_CNT_MAX) begin
						cnt_nxt = rcap_r; // [R18]
						ovf = 1'b1;
						tf_set = 1'b1; // [R1]
						ef_set = 1'b1; // [R5]
					end else begin
						cnt_nxt = cnt_r + 16'h0001;
					end
				end else if (inc) begin
					if (cnt_r == rcap_r) begin
						cnt_nxt = TMR_CNT_MAX; // [R18]
						ovf = 1'b1;
						tf_set = 1'b1; // [R2]
						ef_set = 1'b1; // [R5]
					end else begin
						cnt_nxt = cnt_r - 16'h0001;
					end
				end
			end
			TMR_M_BAUD: begin
				if (inc) begin
					if (cnt_r == TMR_CNT_MAX) begin
						cnt_nxt = rcap_r; // [R13]
						ovf = 1'b1;
						baud_nxt = 1'b1; // [R7] [R8]
					end else begin
						cnt_nxt = cnt_r + 16'h0001;
					end
				end
				// Pin still flags, but no capture or reload
				if (trig_edge && ctrl_r.ext_trigger_enable) begin
					ef_set = 1'b1; // [R5] [R9]
				end
			end
		endcase

		// Clock out toggles on each overflow
		if (ovf && mode_r.clock_out_enable) begin
			cko_nxt = ~cko_r; // [R17]
		end

		// Interrupt flags cleared on service entry
		// Only flags whose clear bit is armed are touched
		xirq_nxt = xirq_r & ~(irq_enter & mode_r.hw_clear_irq); // [R20]

		// Software writes override hardware updates except flag sets
		// Unmapped offsets change nothing
		if (bus_req.wr) begin
			case (bus_req.addr)
				TMR_CTRL_ADDR: begin
					ctrl_nxt = tmr_ctrl_t'(bus_req.wdata); // [R4]
				end
				TMR_MODE_ADDR: begin
					mode_nxt = tmr_mode_ctrl_t'(bus_req.wdata);
					mode_nxt.rsvd = 1'b0;
				end
				TMR_RCAPL_ADDR: begin
					rcap_nxt[7:0] = bus_req.wdata; // [R19]
				end
				TMR_RCAPH_ADDR: begin
					rcap_nxt[15:8] = bus_req.wdata; // [R19]
				end
				TMR_CNTL_ADDR: begin
					cnt_nxt[7:0] = bus_req.wdata;
				end
				TMR_CNTH_ADDR: begin
					cnt_nxt[15:8] = bus_req.wdata;
				end
				TMR_CKCFG_ADDR: begin
					fast_nxt = bus_req.wdata[TMR_FAST_BIT];
				end
				TMR_XIRQ_ADDR: begin
					xirq_nxt = bus_req.wdata[3:0];
				end
				default: begin
					ctrl_nxt = ctrl_r;
				end
			endcase
		end

		// Hardware sets win over a clear in the same cycle
		ctrl_nxt.tmr_overflow_flag = ctrl_nxt.tmr_overflow_flag | (tf_set & ~baud_mode); // [R3] [R4]
		ctrl_nxt.ext_edge_flag = ctrl_nxt.ext_edge_flag | ef_set; // [R6]
		xirq_nxt = xirq_nxt | irq_flag_set;

		// Read data, unmapped reads return zero
		// Data stands for one cycle, then falls back to zero
		if (bus_req.rd) begin
			case (bus_req.addr)
				TMR_CTRL_ADDR: begin
					rdata_nxt = ctrl_r;
				end
				TMR_MODE_ADDR: begin
					rdata_nxt = mode_r;
					rdata_nxt[TMR_MODE_RSVD] = 1'b0;
				end
				TMR_RCAPL_ADDR: begin
					rdata_nxt = rcap_r[7:0];
				end
				TMR_RCAPH_ADDR: begin
					rdata_nxt = rcap_r[15:8];
				end
				TMR_CNTL_ADDR: begin
					rdata_nxt = cnt_r[7:0];
				end
				TMR_CNTH_ADDR: begin
					rdata_nxt = cnt_r[15:8];
				end
				TMR_CKCFG_ADDR: begin
					rdata_nxt[TMR_FAST_BIT] = fast_r;
				end
				TMR_XIRQ_ADDR: begin
					rdata_nxt = {4'h0, xirq_r};
				end
				default: begin
					rdata_nxt = 8'h00;
				end
			endcase
		end
	end

	// Register all state
	// Pin samples reset high so no false edge follows reset
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_r   <= tmr_ctrl_t'(TMR_CTRL_RST);
			mode_r   <= tmr_mode_ctrl_t'(TMR_MODE_RST);
			cnt_r    <= TMR_CNT_RST;
			rcap_r   <= TMR_RCAP_RST;
			fast_r   <= TMR_FAST_RST;
			xirq_r   <= TMR_XIRQ_RST;
			presc_r  <= 4'h0;
			trig_s_r <= 3'h7;
			cpin_s_r <= 3'h7;
			rdata_r  <= 8'h00;
			cko_r    <= 1'b0;
			baud_r   <= 1'b0;
		end else begin
			ctrl_r   <= ctrl_nxt;
			mode_r   <= mode_nxt;
			cnt_r    <= cnt_nxt;
			rcap_r   <= rcap_nxt;
			fast_r   <= fast_nxt;
			xirq_r   <= xirq_nxt;
			presc_r  <= presc_nxt;
			trig_s_r <= trig_s_nxt;
			cpin_s_r <= cpin_s_nxt;
			rdata_r  <= rdata_nxt;
			cko_r    <= cko_nxt;
			baud_r   <= baud_nxt;
		end
	end

	// Outputs from flip-flops
	// Output enable follows its mode bit directly
	assign rdata             = rdata_r;
	assign count_pin_o       = cko_r;
	assign count_pin_oe      = mode_r.clock_out_enable; // [R17]
	assign baud_tick         = baud_r;
	assign tmr_overflow_flag = ctrl_r.tmr_overflow_flag;
	assign ext_edge_flag     = ctrl_r.ext_edge_flag; // [R6]
	assign irq_flag          = xirq_r;

endmodule : tmr_timer2

`default_nettype wire

// ### rtl/tmr_pkg.sv
/*
 * Shared definitions for the 16-bit capture/reload timer:
 * register offsets, field layouts, reset values, modes and
 * prescale counts.
 * Assumes a byte-wide register port with an 8-bit address.
 */
`default_nettype none

package tmr_pkg;

	// Register offsets
	localparam logic [7:0] TMR_CTRL_ADDR   = 8'hC8;
	localparam logic [7:0] TMR_MODE_ADDR   = 8'hC9;
	localparam logic [7:0] TMR_RCAPL_ADDR  = 8'hCA;
	localparam logic [7:0] TMR_RCAPH_ADDR  = 8'hCB;
	localparam logic [7:0] TMR_CNTL_ADDR   = 8'hCC;
	localparam logic [7:0] TMR_CNTH_ADDR   = 8'hCD;
	localparam logic [7:0] TMR_CKCFG_ADDR  = 8'hCE;
	localparam logic [7:0] TMR_XIRQ_ADDR   = 8'hCF;

	// Field positions
	localparam int         TMR_FAST_BIT    = 5;
	localparam int         TMR_MODE_RSVD   = 2;

	// Reset values
	localparam logic [7:0]  TMR_CTRL_RST   = 8'h00;
	localparam logic [7:0]  TMR_MODE_RST   = 8'h00;
	localparam logic [15:0] TMR_CNT_RST    = 16'h0000;
	localparam logic [15:0] TMR_RCAP_RST   = 16'h0000;
	localparam logic [3:0]  TMR_XIRQ_RST   = 4'h0;
	localparam logic        TMR_FAST_RST   = 1'b0;

	// Count limits
	localparam logic [15:0] TMR_CNT_MAX    = 16'hFFFF;
	localparam logic [15:0] TMR_CNT_ZERO   = 16'h0000;

	// Clocks per tick
	localparam logic [3:0]  TMR_BAUD_DIV   = 4'h2;
	localparam logic [3:0]  TMR_FAST_DIV   = 4'h4;
	localparam logic [3:0]  TMR_SLOW_DIV   = 4'hC;

	// Control register layout, bit 7 first
	typedef struct packed {
		logic tmr_overflow_flag;
		logic ext_edge_flag;
		logic rx_baud_select;
		logic tx_baud_select;
		logic ext_trigger_enable;
		logic run_control;
		logic count_source_select;
		logic capture_reload_select;
	} tmr_ctrl_t;

	// Mode control register layout, bit 7 first
	typedef struct packed {
		logic [3:0] hw_clear_irq;
		logic       capture_reset_enable;
		logic       rsvd;
		logic       clock_out_enable;
		logic       down_count_enable;
	} tmr_mode_ctrl_t;

	// Register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tmr_bus_req_t;

	// Operating modes
	typedef enum logic [3:0] {
		TMR_M_CAPTURE = 4'b0001,
		TMR_M_RELOAD  = 4'b0010,
		TMR_M_DOWN    = 4'b0100,
		TMR_M_BAUD    = 4'b1000
	} tmr_mode_t;

endpackage : tmr_pkg

`default_nettype wire

// ### tb/tmr_timer2_chk.sv
/* Port checker for tmr_timer2.
 * Bound to the design; sees its ports only. */
`default_nettype none
module tmr_timer2_chk
	import tmr_pkg::*;
(
	// Clock and reset
	input wire logic         clk,
	input wire logic         reset,
	// Register port and status
	input wire tmr_bus_req_t bus_req,
	input wire logic         baud_tick,
	input wire logic         tmr_overflow_flag,
	input wire logic         ext_edge_flag,
	input wire logic         count_pin_oe,
	// External interrupts
	input wire logic [3:0]   irq_flag_set,
	input wire logic [3:0]   irq_enter,
	input wire logic [3:0]   irq_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [7:0] ctrl_r, ctrl_nxt, mode_r, mode_nxt;
	logic       ctrl_wr, mode_wr, baud_sel, tf_clr, ef_clr;
	// Shadow of software writes
	assign ctrl_wr  = bus_req.wr && bus_req.addr == TMR_CTRL_ADDR;
	assign mode_wr  = bus_req.wr && bus_req.addr == TMR_MODE_ADDR;
	assign tf_clr   = ctrl_wr && !bus_req.wdata[7];
	assign ef_clr   = ctrl_wr && !bus_req.wdata[6];
	assign baud_sel = ctrl_r[5] | ctrl_r[4];
	always_comb begin
		ctrl_nxt = ctrl_wr ? bus_req.wdata : ctrl_r;
		mode_nxt = mode_wr ? bus_req.wdata : mode_r;
	end
	always_ff @(posedge clk) begin
		ctrl_r <= reset ? 8'h00 : ctrl_nxt;
		mode_r <= reset ? 8'h00 : mode_nxt;
	end
	// Baud mode held for three cycles
	sequence s_baud_held;
		baud_sel [*3];
	endsequence
	// Service entry with hardware clear armed
	sequence s_enter_clr;
		!bus_req.wr && (irq_enter & mode_r[7:4] & ~irq_flag_set) != 4'h0;
	endsequence
	AST_TF_SW_CLEAR: assert property ($fell(tmr_overflow_flag) |-> $past(tf_clr))
		else $error("overflow flag fell without a write");
	AST_EF_SW_CLEAR: assert property ($fell(ext_edge_flag) |-> $past(ef_clr))
		else $error("edge flag fell without a write");
	AST_TF_NO_BAUD: assert property (s_baud_held |=> !$rose(tmr_overflow_flag) || $past(ctrl_wr))
		else $error("overflow flag set in baud mode");
	AST_BAUD_SRC: assert property (baud_tick |-> $past(baud_sel) || $past(baud_sel, 2))
		else $error("baud tick outside baud mode");
	AST_BAUD_GAP: assert property (baud_tick |=> !baud_tick)
		else $error("baud ticks closer than two clocks");
	AST_RUN_STOP: assert property (!ctrl_r[2] && !$past(ctrl_r[2]) |-> !baud_tick)
		else $error("tick while stopped");
	AST_OE_FOLLOW: assert property (mode_wr |=> count_pin_oe == $past(bus_req.wdata[1]))
		else $error("output enable does not follow its bit");
	AST_IRQ_CLR: assert property (s_enter_clr |=>
		(irq_flag & $past(irq_enter & mode_r[7:4] & ~irq_flag_set)) == 4'h0)
		else $error("irq flag not cleared on entry");
endmodule : tmr_timer2_chk

bind tmr_timer2 tmr_timer2_chk i_tmr_timer2_chk (.clk(clk), .reset(reset), .bus_req(bus_req),
	.baud_tick(baud_tick), .tmr_overflow_flag(tmr_overflow_flag), .ext_edge_flag(ext_edge_flag),
	.count_pin_oe(count_pin_oe), .irq_flag_set(irq_flag_set), .irq_enter(irq_enter), .irq_flag(irq_flag));
`default_nettype wire

// ### tb/tmr_pins_model.sv
/* Far-side pins: trigger level and bursts of count pulses.
 * Commanded by the bench; pins idle high as on a pull-up. */
`default_nettype none
module tmr_pins_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Bench commands
	input  wire logic trig_cmd,
	input  wire logic burst_go,
	// Pins and status
	output var  logic trigger_pin,
	output var  logic count_drive,
	output var  logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] step_r = 5'h00;
	// Pins change just after the edge
	always @(posedge clk) begin
		trigger_pin <= reset ? 1'b1 : trig_cmd;
		step_r      <= burst_go ? 5'h18 : step_r - {4'h0, busy};
	end
	// Three falling edges per burst
	assign count_drive = ~step_r[2];
	assign busy        = step_r != 5'h00;
endmodule : tmr_pins_model
`default_nettype wire

// ### tb/tb_tmr_timer2.sv
/* Bench for tmr_timer2: register tasks and scenarios.
 * Needs tmr_pkg, the pin model and the bound checker. */
`default_nettype none
module tb_tmr_timer2 import tmr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic         clk = 1'b0, reset = 1'b1, trig_cmd = 1'b1, burst_go = 1'b0;
	logic         trigger_pin, count_drive, busy, count_pin_i, count_pin_o, count_pin_oe;
	logic         baud_tick, tmr_overflow_flag, ext_edge_flag;
	logic [3:0]   irq_flag_set = 4'h0, irq_enter = 4'h0, irq_flag;
	logic [7:0]   rdata, flags;
	tmr_bus_req_t bus_req = '0;
	int           miscompares = 0, checks_done = 0, cyc = 0, n;
	// Design and far-side pins
	tmr_timer2 i_tmr_timer2 (.clk(clk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
		.trigger_pin(trigger_pin), .count_pin_i(count_pin_i), .count_pin_o(count_pin_o),
		.count_pin_oe(count_pin_oe), .baud_tick(baud_tick), .tmr_overflow_flag(tmr_overflow_flag),
		.ext_edge_flag(ext_edge_flag), .irq_flag_set(irq_flag_set), .irq_enter(irq_enter), .irq_flag(irq_flag));
	tmr_pins_model i_tmr_pins_model (.clk(clk), .reset(reset), .trig_cmd(trig_cmd), .burst_go(burst_go),
		.trigger_pin(trigger_pin), .count_drive(count_drive), .busy(busy));
	// Pin level and flag view
	assign count_pin_i = count_pin_oe ? count_pin_o : count_drive;
	assign flags       = {6'h00, tmr_overflow_flag, ext_edge_flag};
	always #5 clk = ~clk;
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			summarize();
		end
	end
	task chk(input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task w(input logic [7:0] a, d);
		bus_req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		bus_req <= '0;
		@(posedge clk);
	endtask : w
	task r(input logic [7:0] a, e);
		bus_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		bus_req <= '0;
		#1 chk(rdata, e);
		@(posedge clk);
	endtask : r
	task summarize;
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		// Reset values, unmapped read
		r(TMR_CTRL_ADDR, 8'h00);
		r(TMR_MODE_ADDR, 8'h00);
		r(8'h10, 8'h00);
		// Reload on overflow, stop holds count
		w(TMR_RCAPL_ADDR, 8'hFD);
		w(TMR_RCAPH_ADDR, 8'h12);
		r(TMR_RCAPL_ADDR, 8'hFD);
		w(TMR_CKCFG_ADDR, 8'h20);
		w(TMR_CNTL_ADDR, 8'hFF);
		w(TMR_CNTH_ADDR, 8'hFF);
		w(TMR_CTRL_ADDR, 8'h04);
		repeat (6) @(posedge clk);
		chk(flags, 8'h02);
		chk({7'h00, count_pin_o}, 8'h00);
		w(TMR_CTRL_ADDR, 8'h80);
		repeat (40) @(posedge clk);
		r(TMR_CNTH_ADDR, 8'h12);
		r(TMR_CTRL_ADDR, 8'h80);
		w(TMR_CTRL_ADDR, 8'h00);
		r(TMR_CTRL_ADDR, 8'h00);
		// Capture with count reset, then trigger ignored
		w(TMR_MODE_ADDR, 8'h08);
		w(TMR_CNTL_ADDR, 8'h34);
		w(TMR_CNTH_ADDR, 8'h12);
		w(TMR_CTRL_ADDR, 8'h09);
		trig_cmd <= 1'b0;
		repeat (6) @(posedge clk);
		chk(flags, 8'h01);
		r(TMR_RCAPL_ADDR, 8'h34);
		r(TMR_RCAPH_ADDR, 8'h12);
		r(TMR_CNTL_ADDR, 8'h00);
		trig_cmd <= 1'b1;
		w(TMR_CTRL_ADDR, 8'h01);
		trig_cmd <= 1'b0;
		repeat (6) @(posedge clk);
		chk(flags, 8'h00);
		r(TMR_RCAPL_ADDR, 8'h34);
		// Baud mode from either select, capture select ignored
		w(TMR_RCAPL_ADDR, 8'hF0);
		w(TMR_RCAPH_ADDR, 8'hFF);
		for (int i = 0; i < 2; i++) begin
			w(TMR_CNTL_ADDR, 8'hFE);
			w(TMR_CNTH_ADDR, 8'hFF);
			w(TMR_CTRL_ADDR, i ? 8'h15 : 8'h24);
			n = 0;
			while (baud_tick !== 1'b1 && n < 99) begin
				@(posedge clk);
				n++;
			end
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (baud_tick !== 1'b1 && n < 99);
			chk(n[7:0], 8'h20);
			chk(flags, 8'h00);
			w(TMR_CTRL_ADDR, 8'h00);
		end
		// Low trigger counts down to reload, high counts up
		w(TMR_MODE_ADDR, 8'h01);
		for (int i = 0; i < 2; i++) begin
			w(TMR_CNTL_ADDR, 8'hF2);
			w(TMR_CNTH_ADDR, 8'hFF);
			w(TMR_CTRL_ADDR, 8'h04);
			repeat (16) @(posedge clk);
			chk(flags, i ? 8'h00 : 8'h03);
			w(TMR_CTRL_ADDR, 8'h00);
			trig_cmd <= 1'b1;
		end
		// Count pin edges only
		w(TMR_MODE_ADDR, 8'h00);
		w(TMR_CNTL_ADDR, 8'h00);
		w(TMR_CTRL_ADDR, 8'h06);
		burst_go <= 1'b1;
		@(posedge clk);
		burst_go <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (busy && n < 60);
		repeat (4) @(posedge clk);
		w(TMR_CTRL_ADDR, 8'h00);
		r(TMR_CNTL_ADDR, 8'h03);
		// Clock-out enable
		w(TMR_MODE_ADDR, 8'h02);
		chk({7'h00, count_pin_oe}, 8'h01);
		w(TMR_CNTL_ADDR, 8'hFF);
		w(TMR_CNTH_ADDR, 8'hFF);
		w(TMR_CTRL_ADDR, 8'h04);
		repeat (6) @(posedge clk);
		chk({7'h00, count_pin_o}, 8'h01);
		w(TMR_CTRL_ADDR, 8'h00);
		// Hardware clear of irq2 and irq4 on entry
		w(TMR_MODE_ADDR, 8'h50);
		irq_flag_set <= 4'hF;
		@(posedge clk);
		irq_flag_set <= 4'h0;
		irq_enter <= 4'hF;
		@(posedge clk);
		irq_enter <= 4'h0;
		@(posedge clk);
		chk({4'h0, irq_flag}, 8'h0A);
		summarize();
	end
endmodule : tb_tmr_timer2
`default_nettype wire
